// >>> dv/adaptive_input_deserializer_test.sv
// self-checking bench for the adaptive input deserializer
`timescale 1ns/10ps
module adaptive_input_deserializer_test;
  import aid_pkg::*;
  localparam int TAPS_N = 8;
  logic ref_clk, arst_n, hsel, hwrite, word_ready, pair_din;
  logic hreadyout, hresp, word_valid, lock_status;
  logic [1:0] hs_din, mode, htrans;
  logic [2:0] hsize;
  logic [3:0] word_data, held;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  integer seed = 88737;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [1:0] t_mode [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0};
  logic [31:0] t_ctrl [6] = '{32'h30, 32'h32, 32'h34, 32'h36, 32'h32, 32'h30};

  aid_deserializer #(.TAPS(TAPS_N), .CELL_IDX(0), .TOP_SIDE(1'b0)) i_aid_deserializer (
    .ref_clk(ref_clk), .arst_n(arst_n), .hs_din(hs_din), .pair_din(pair_din),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .lock_status(lock_status));
  aid_tx_model i_aid_tx_model (.ref_clk(ref_clk), .arst_n(arst_n), .mode(mode),
    .hs_din(hs_din), .pair_din(pair_din));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected word of a steady stream: rise bit high, fall and pair lane high only in mode 1
  function automatic logic [3:0] exp_word(input logic [1:0] m, input logic [31:0] c);
    logic r, f, p;
    r = 1'b1;
    f = (m == 2'h1);
    p = (m == 2'h1);
    if (c[CTRL_X4_BIT]) exp_word = c[CTRL_DDR_BIT] ? {r, f, r, f} : {p, r, p, r};
    else exp_word = c[CTRL_DDR_BIT] ? {2'h0, r, f} : {2'h0, r, r};
  endfunction

  task automatic end_sim;
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // single ahb-lite transfer; the master waits on hready rather than assuming zero wait
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdo);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdo = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check(rd & mask, exp);
    check(hresp, 1'b0);
  endtask

  // collect n words under random stalls; the first six flush the mode change
  task automatic words(input int n, input logic [3:0] exp, input logic cons);
    int got;
    logic [3:0] first;
    got = 0;
    first = 4'h0;
    while (got < n) begin
      @(negedge ref_clk);
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
        if (got == 6) first = word_data;
        if (got == 6 && cons) check({first[3:2], first[1] ^ first[0]}, 3'h1);
        if (got >= 6) check(word_data, cons ? first : exp);
        got++;
      end
      @(posedge ref_clk);
      word_ready <= 1'($random(seed));
    end
  endtask

  // hang guard, far above the fewer than two thousand cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim;
    end
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    word_ready = 1'b0;
    mode = 2'h1;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values, capability bits and an unmapped word
    rd_chk(CTRL_OFF, 32'hffff_ffff, 32'h31);
    rd_chk(TAPS_OFF, 32'hffff_ffff, TAPS_N);
    rd_chk(STAT_OFF, 32'hc, 32'hc);
    ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
    rd_chk(8'h0c, 32'hffff_ffff, 32'h0);
    repeat (4) begin
      v = $random(seed) & 32'h777;
      ahb(1'b1, CTRL_OFF, v, rd);
      rd_chk(CTRL_OFF, 32'h777, v);
    end
    // frozen delay at every fixed tap reports holding at that tap
    for (int t = 0; t < 8; t++) begin
      ahb(1'b1, CTRL_OFF, 32'((t << 8) | 32'h30), rd);
      repeat (40) @(posedge ref_clk);
      rd_chk(STAT_OFF, 32'h71, 32'((t << 4) | 1));
      check(lock_status, 1'b1);
    end
    // tracking on clean data centres the window of widths 2 to 5
    for (int w = 2; w < 6; w++) begin
      ahb(1'b1, CTRL_OFF, 32'((w << 4) | 1), rd);
      repeat (120) @(posedge ref_clk);
      rd_chk(STAT_OFF, 32'h71, 32'(((w / 2) << 4) | 1));
    end
    // every gearbox mode with its expected word
    for (int i = 0; i < 6; i++) begin
      mode <= t_mode[i];
      ahb(1'b1, CTRL_OFF, t_ctrl[i], rd);
      words(20, exp_word(t_mode[i], t_ctrl[i]), t_mode[i] == 2'h0);
    end
    // long stall: word stands, buffer overflows, flag clears by writing one
    mode <= 2'h1;
    ahb(1'b1, CTRL_OFF, 32'h30, rd);
    word_ready <= 1'b0;
    repeat (10) @(posedge ref_clk);
    held = word_data;
    repeat (30) @(posedge ref_clk);
    check({word_valid, word_data}, {1'b1, held});
    rd_chk(STAT_OFF, 32'h2, 32'h2);
    word_ready <= 1'b1;
    repeat (10) @(posedge ref_clk);
    ahb(1'b1, STAT_OFF, 32'h2, rd);
    rd_chk(STAT_OFF, 32'h2, 32'h0);
    end_sim;
  end
endmodule

// >>> dv/aid_tx_model.sv
// far-side transmitter model that drives the cell's input pins
`timescale 1ns/10ps
module aid_tx_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] mode,
  output logic [1:0] hs_din,
  output logic pair_din
);
  // new bits just after each rising edge, as a source-synchronous sender would launch them
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_din <= 2'h0;
      pair_din <= 1'b0;
    end else begin
      case (mode)
        2'h0: hs_din <= {hs_din[0], ~hs_din[0]}; // plain toggling traffic, no training word
        2'h1: hs_din <= 2'h3; // constant level on both edges
        default: hs_din <= 2'h1; // rise bit high, fall bit low
      endcase
      pair_din <= (mode == 2'h1); // neighbour lane, already realigned to this cycle
    end
  end
endmodule

// >>> hdl/aid_deserializer.sv
// adaptive input cell: delay chain aligner, ddr/shift gearbox, ahb-lite registers
//
// Overview of operation
// - each input bit runs through tapped delay chain
// - scan taps for a transition-free sampling point
// - keep watching data, move sample point on drift
// - window slides; stability judged only by transitions
// - any toggling traffic aligns, no training pattern; here data toggling every cycle never locks with win_reg of 2 or more
// - acquisition window width is software configurable
// - control selects tracking or frozen fixed delay
// - single and double data rate inputs supported
// - gearbox widens data into slower word domain
// - every cell does ddr capture and x2 shift
// - cells first/second or third/fourth pair into x4
// - aligner only on first/third cells, not top side
// - high to low speed handoff needs no user action
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module aid_deserializer #(
  parameter int TAPS = 8,
  parameter int CELL_IDX = 0,
  parameter bit TOP_SIDE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] hs_din,
  input wire logic pair_din,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic lock_status
);
  import aid_pkg::*;

  localparam int PW = $clog2(TAPS);
  localparam bit HAS_ALN = ((CELL_IDX % 2) == 0) && !TOP_SIDE;
  localparam bit X4_OK = ((CELL_IDX % 2) == 0);
  localparam int ECW = $clog2(EVAL_CYC + 1);

  logic track_reg, ddr_reg, x4_reg, ovf_reg;
  logic [2:0] win_reg, fix_reg;
  logic [PW-1:0] pos_reg;
  logic [TAPS-1:0] chain_reg;
  logic [TAPS-2:0] edge_reg;
  logic [ECW-1:0] eval_reg;
  aid_aln_t aln_reg;
  logic [3:0] shift_reg;
  logic [2:0] bits_reg;
  logic [3:0] skid_reg;
  logic skid_valid_reg;
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;

  // ahb address phase decode
  logic addr_ok;
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

  // bus never stalls, always answers okay
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // latch address phase for the following data phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // read data is registered at the address phase so it stands in the data phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFF: begin
        rd_mux[CTRL_TRACK_BIT] = track_reg;
        rd_mux[CTRL_DDR_BIT] = ddr_reg;
        rd_mux[CTRL_X4_BIT] = x4_reg;
        rd_mux[CTRL_WIN_LSB +: FLD_W] = win_reg;
        rd_mux[CTRL_FIX_LSB +: FLD_W] = fix_reg;
      end
      STAT_OFF: begin
        rd_mux[STAT_LOCK_BIT] = lock_status;
        rd_mux[STAT_OVF_BIT] = ovf_reg;
        rd_mux[STAT_X4OK_BIT] = X4_OK;
        rd_mux[STAT_ALN_BIT] = HAS_ALN;
        rd_mux[STAT_POS_LSB +: PW] = pos_reg;
      end
      TAPS_OFF: rd_mux[PW:0] = (PW + 1)'(TAPS);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // control register; x4 only sticks where the cell can pair
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      track_reg <= CTRL_TRACK_RST;
      ddr_reg <= CTRL_DDR_RST;
      x4_reg <= CTRL_X4_RST;
      win_reg <= CTRL_WIN_RST;
      fix_reg <= CTRL_FIX_RST;
    end else if (wr_pend_reg && addr_reg == CTRL_OFF) begin
      track_reg <= hwdata[CTRL_TRACK_BIT];
      ddr_reg <= hwdata[CTRL_DDR_BIT];
      x4_reg <= hwdata[CTRL_X4_BIT] && X4_OK;
      win_reg <= hwdata[CTRL_WIN_LSB +: FLD_W];
      fix_reg <= hwdata[CTRL_FIX_LSB +: FLD_W];
    end
  end

  // delay chain: ddr shifts two bits a cycle, rise bit first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_reg <= '0;
    end else if (ddr_reg) begin
      chain_reg <= {chain_reg[TAPS-3:0], hs_din[0], hs_din[1]};
    end else begin
      chain_reg <= {chain_reg[TAPS-2:0], hs_din[0]};
    end
  end

  // per-tap transition detectors, sticky over one evaluation period
  logic eval_end;
  assign eval_end = (eval_reg == ECW'(EVAL_CYC - 1));
  genvar gt;
  generate
    for (gt = 0; gt < TAPS - 1; gt++) begin : g_edge
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          edge_reg[gt] <= 1'b0;
        end else if (eval_end) begin
          edge_reg[gt] <= 1'b0;
        end else if (chain_reg[gt] ^ chain_reg[gt+1]) begin
          edge_reg[gt] <= 1'b1; // only transitions count, not levels
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      eval_reg <= '0;
    end else if (eval_end) begin
      eval_reg <= '0;
    end else begin
      eval_reg <= eval_reg + ECW'(1);
    end
  end

  // slide the window along the chain; first clean span wins
  logic found;
  logic [PW-1:0] best_pos;
  always_comb begin
    logic clean;
    clean = 1'b0;
    found = 1'b0;
    best_pos = pos_reg;
    for (int s = 0; s < TAPS - 1; s++) begin
      clean = (s + int'(win_reg) <= TAPS - 1);
      for (int k = 0; k < 8; k++) begin
        if (k < int'(win_reg) && s + k < TAPS - 1 && edge_reg[s+k]) begin
          clean = 1'b0;
        end
      end
      if (clean && !found) begin
        found = 1'b1;
        best_pos = PW'(s + int'(win_reg) / 2);
      end
    end
  end

  // aligner: acquire, track drift, or hold a fixed delay
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aln_reg <= ALN_ACQ;
      pos_reg <= '0;
    end else if (!HAS_ALN) begin
      aln_reg <= ALN_HOLD; // no aligner: tap zero only
      pos_reg <= '0;
    end else if (!track_reg) begin
      aln_reg <= ALN_HOLD;
      pos_reg <= PW'(fix_reg);
    end else if (eval_end) begin
      case (aln_reg)
        ALN_ACQ: begin
          if (found) begin
            aln_reg <= ALN_TRACK; // locks once a window of win_reg taps stays transition-free
            pos_reg <= best_pos;
          end
        end
        ALN_TRACK: begin
          if (found) begin
            pos_reg <= best_pos; // walk with the data
          end else begin
            aln_reg <= ALN_ACQ;
          end
        end
        ALN_HOLD: aln_reg <= ALN_ACQ;
        default: aln_reg <= ALN_ACQ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_status <= 1'b0;
    end else begin
      lock_status <= (aln_reg != ALN_ACQ);
    end
  end

  // sampled bits: ddr takes two taps, sdr x4 pairs in the neighbour cell's bit
  logic samp_a, samp_b;
  logic [2:0] need, step;
  assign samp_a = chain_reg[pos_reg];
  assign samp_b = ddr_reg ? chain_reg[(pos_reg + PW'(1)) % TAPS] : pair_din;
  assign need = x4_reg ? 3'h4 : 3'h2;
  assign step = (ddr_reg || x4_reg) ? 3'h2 : 3'h1;

  // gearbox: oldest bit lands in the top of the word
  logic word_done;
  logic [3:0] shift_next;
  always_comb begin
    shift_next = shift_reg;
    if (step == 3'h2) begin
      shift_next = {shift_reg[1:0], samp_b, samp_a};
    end else begin
      shift_next = {shift_reg[2:0], samp_a};
    end
  end
  assign word_done = (bits_reg + step >= need);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 4'h0;
      bits_reg <= 3'h0;
    end else begin
      shift_reg <= shift_next;
      bits_reg <= word_done ? 3'h0 : bits_reg + step; // self-timed slow strobe
    end
  end

  // two-entry buffer: output stage plus skid stage
  logic push, in_ready;
  logic [3:0] new_word;
  // a draining output frees the skid slot in the same cycle, so a short stall drops nothing
  assign in_ready = !skid_valid_reg || word_ready;
  assign push = word_done && in_ready;
  assign new_word = x4_reg ? shift_next : {2'h0, shift_next[1:0]};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_valid <= 1'b0;
      word_data <= 4'h0;
      skid_valid_reg <= 1'b0;
      skid_reg <= 4'h0;
    end else if (word_ready || !word_valid) begin
      if (skid_valid_reg) begin
        word_data <= skid_reg;
        word_valid <= 1'b1;
        skid_valid_reg <= push;
        if (push) begin
          skid_reg <= new_word;
        end
      end else begin
        word_valid <= push;
        if (push) begin
          word_data <= new_word;
        end
      end
    end else if (push) begin
      skid_reg <= new_word;
      skid_valid_reg <= 1'b1;
    end
  end

  // a word dropped on a full buffer is flagged; a new drop beats the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_reg <= 1'b0;
    end else if (word_done && !in_ready) begin
      ovf_reg <= 1'b1;
    end else if (wr_pend_reg && addr_reg == STAT_OFF && hwdata[STAT_OVF_BIT]) begin
      ovf_reg <= 1'b0;
    end
  end

  // checks
  chk_freeze_fixed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (HAS_ALN && !track_reg) |=> (pos_reg == PW'($past(fix_reg))))
    else $error("frozen aligner not at fixed tap");
  chk_noaln_tapzero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !HAS_ALN |-> (pos_reg == '0))
    else $error("cell without aligner moved its tap");
  chk_lock_found: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (HAS_ALN && track_reg && aln_reg == ALN_ACQ && eval_end && found) |=> ##1 lock_status)
    else $error("clean window found but no lock");
  chk_track_move: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (HAS_ALN && track_reg && aln_reg == ALN_TRACK && eval_end && found)
    |=> (pos_reg == $past(best_pos)))
    else $error("tracking did not follow the window");
  chk_pos_steady: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (track_reg && !eval_end && $past(track_reg)) |=> $stable(pos_reg))
    else $error("sample point moved outside evaluation end");
  chk_x4_pairing: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !X4_OK |-> !x4_reg)
    else $error("x4 set on a cell that cannot pair");
  chk_word_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (word_done && !ddr_reg && x4_reg && $stable(x4_reg) && !wr_pend_reg)
    |=> !word_done ##1 word_done)
    else $error("x4 sdr word not every second cycle");
  chk_buf_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (word_valid && !word_ready) |=> (word_valid && $stable(word_data)))
    else $error("stalled word changed or vanished");
  chk_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (word_done && !in_ready) |=> ovf_reg)
    else $error("dropped word not flagged");
  cov_lock: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(lock_status));
  cov_buf_full: cover property (@(posedge ref_clk) disable iff (!arst_n)
    skid_valid_reg && word_valid);
  cov_x4_word: cover property (@(posedge ref_clk) disable iff (!arst_n)
    x4_reg && word_valid && word_ready);
  cov_freeze: cover property (@(posedge ref_clk) disable iff (!arst_n)
    !track_reg && aln_reg == ALN_HOLD);
endmodule

// >>> hdl/aid_pkg.sv
// shared constants for the adaptive input deserializer
package aid_pkg;
  // clock and timing
  localparam int CLK_NS = 20;
  localparam int EVAL_NS = 640;
  localparam int EVAL_CYC = (EVAL_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] TAPS_OFF = 8'h08;
  // control field positions
  localparam int CTRL_TRACK_BIT = 0;
  localparam int CTRL_DDR_BIT = 1;
  localparam int CTRL_X4_BIT = 2;
  localparam int CTRL_WIN_LSB = 4;
  localparam int CTRL_FIX_LSB = 8;
  localparam int FLD_W = 3;
  // status field positions
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_X4OK_BIT = 2;
  localparam int STAT_ALN_BIT = 3;
  localparam int STAT_POS_LSB = 4;
  // reset values
  localparam logic CTRL_TRACK_RST = 1'b1;
  localparam logic CTRL_DDR_RST = 1'b0;
  localparam logic CTRL_X4_RST = 1'b0;
  localparam logic [2:0] CTRL_WIN_RST = 3'h3;
  localparam logic [2:0] CTRL_FIX_RST = 3'h0;
  // aligner states
  typedef enum logic [1:0] {ALN_ACQ, ALN_TRACK, ALN_HOLD} aid_aln_t;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
